// *** bench/watchdog_interval_timer_tb.sv ***
// Bench for the watchdog/interval timer over APB
// Assumes default widths and the checker module
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic cpu_halt = 1'b0;
  logic cpu_stop = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, irq, irq_hi, nmi, rreq;
  int n_fail = 0;
  int n_compared = 0;
  int n_nmi = 0;
  int n_rst = 0;
  int cyc = 0;
  int el;
  localparam int P11 = 2048;
  localparam int P13 = 8192;
  watchdog_interval_timer i_watchdog_interval_timer (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_halt, .cpu_stop, .interval_irq_request(irq),
    .interval_irq_high_priority(irq_hi), .wd_nmi(nmi), .wd_reset_req(rreq));
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    n_nmi <= n_nmi + int'(nmi === 1'b1);
    n_rst <= n_rst + int'(rreq === 1'b1);
    if (cyc == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task wait_for(input int sel, input int lim);
    int n0;
    n0 = n_nmi + n_rst;
    el = 0;
    while (el < lim && ((sel != 0) ? (n_nmi + n_rst == n0) : (irq !== 1'b1)))
    begin
      @(posedge core_clk);
      el++;
    end
  endtask : wait_for
  task complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk({er, rd}, {i == 4, i == 3 ? 32'h2 : 32'h0});
    end
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h80);
    repeat (P13 + 100) @(posedge core_clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(33'(rd) | 33'(n_nmi + n_rst), 33'h0);
    $display("test 1 done");
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h04, 32'h88);
    wait_for(0, P13 + 100);
    chk(33'(el >= P13 - 17 && el <= P13 + 8), 33'h1);
    apb(1'b1, 8'h0c, 32'h2);
    @(posedge core_clk);
    chk(33'(irq), 33'h0);
    repeat (P13) @(posedge core_clk);
    apb(1'b0, 8'h08, 32'h0);
    chk({irq, rd}, 33'h1);
    $display("test 2 done");
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    chk(33'(n_nmi), 33'h1);
    chk(33'(rd), 33'h98);
    apb(1'b1, 8'h00, 32'h0);
    cpu_halt <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h04, 32'h80);
      repeat (P11 - 200) @(posedge core_clk);
    end
    chk(33'(n_rst), 33'h0);
    apb(1'b1, 8'h04, 32'h80);
    repeat (1000) @(posedge core_clk);
    cpu_stop <= 1'b1;
    repeat (3000) @(posedge core_clk);
    cpu_stop <= 1'b0;
    wait_for(1, P11);
    chk(33'(n_rst), 33'h1);
    chk(33'(el >= P11 - 1020 && el <= P11 - 990), 33'h1);
    $display("test 3 done");
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b1, 8'h04, 32'h90);
    wait_for(1, P11 + 100);
    chk(33'(el >= P11 - 17 && el <= P11 + 8), 33'h1);
    chk(33'(n_nmi), 33'h2);
    $display("test 4 done");
    complete_run();
  end
endmodule : watchdog_interval_timer_tb
bind watchdog_interval_timer wdt_sva i_wdt_sva (.core_clk, .rst_n, .psel, .penable, .prdata, .pready, .pslverr,
  .cpu_stop, .interval_irq_request, .interval_irq_high_priority, .wd_nmi, .wd_reset_req);
`default_nettype wire

// *** bench/wdt_sva.sv ***
// Checker for the watchdog/interval timer ports
// Assumes a bind to the top module by port name
`timescale 1ns/1ps
`default_nettype none
module wdt_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_stop,
  input wire logic interval_irq_request,
  input wire logic interval_irq_high_priority,
  input wire logic wd_nmi,
  input wire logic wd_reset_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence frozen_s;
    cpu_stop [*4];
  endsequence
  a_ready_next: assert property (setup_s |=> pready) else $error("no ready after setup");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused read not zero");
  a_prio_same: assert property (interval_irq_high_priority == interval_irq_request)
    else $error("priority marker differs");
  a_nmi_pulse: assert property (wd_nmi |=> !wd_nmi) else $error("nmi too long");
  a_rst_pulse: assert property (wd_reset_req |=> !wd_reset_req) else $error("reset too long");
  a_one_action: assert property (!(wd_nmi && wd_reset_req)) else $error("both actions");
  a_stop_freeze: assert property (frozen_s |-> !wd_reset_req) else $error("reset in stop");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !wd_nmi && !wd_reset_req
    && !interval_irq_request) else $error("output active after reset");
endmodule : wdt_sva
`default_nettype wire

// *** common/wdt_consts.svh ***
// Watchdog/interval timer constants: register offsets, fields, reset values
// Assumes a 32-bit APB slave with one register per aligned word
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_ADDR_W 8
`define WDT_OFF_CLKSEL 8'h00
`define WDT_OFF_MODE 8'h04
`define WDT_OFF_STATUS 8'h08
`define WDT_OFF_IRQCTL 8'h0c
`define WDT_BIT_RUN 7
`define WDT_BIT_LOOP 4
`define WDT_BIT_ACTION 3
`define WDT_BIT_FLAG 0
`define WDT_BIT_MASK 1
`define WDT_RESET_BYTE 8'h00
`define WDT_PRESC_W 4
`define WDT_SEL_P11 3'h0
`define WDT_SEL_P13 3'h2
`define WDT_SEL_P15 3'h4
`define WDT_SEL_P17 3'h6
`define WDT_TAP_P11 5'h0b
`define WDT_TAP_P13 5'h0d
`define WDT_TAP_P15 5'h0f
`define WDT_TAP_P17 5'h11
`define WDT_CNT_W 17
`endif

// *** common/wdt_pkg.sv ***
// Types for the watchdog/interval timer
// Assumes the constants header is included by the design
package wdt_pkg;
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_INTERVAL,
    MODE_WD_NMI,
    MODE_WD_RESET
  } wd_mode_t;
endpackage : wdt_pkg

// *** core/watchdog_interval_timer.sv ***
// Watchdog and interval timer with an APB register file
// Assumes a synchronous system clock, halt/stop status from the core, and an
// interrupt controller that applies priority among maskable sources
//
// What this block does
// - Loop select bit 4 set means watchdog mode
// - Clock select codes give 2^11..2^17 periods
// - Writing run bit 1 starts counting unless mode is 00
// - Each run write restarts count from zero
// - Watchdog overflow gives reset or NMI per bit3
// - Watchdog counts in halt, freezes in stop
// - Prescaler not cleared; first period slightly short
// - Mode 01 gives repeating interval events
// - Interval counting waits for run bit
// - Interval event is maskable, gated by mask
// - Interval request has top maskable priority
// - Interval counts in halt, freezes in stop
// - Loop select set locks out interval mode
// - Run bit ignores writes of zero
// - Mode bits ignore writes of zero
// - Pending flag on watchdog select raises NMI
// - Reset clears mode and clock select registers
//
// Design decisions made here: the register offsets and the APB slave port.
`include "wdt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer #(
  parameter int PRESC_W = `WDT_PRESC_W,
  parameter int CNT_W = `WDT_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  output logic interval_irq_request,
  output logic interval_irq_high_priority,
  output logic wd_nmi,
  output logic wd_reset_req
);
  localparam int PW = PRESC_W + CNT_W;

  // Register state
  logic [2:0] wd_clock_select_register_q;
  logic run_q;
  logic loop_detect_select_q;
  logic overflow_action_select_q;
  logic interval_irq_flag_q;
  logic interval_irq_mask_q;

  // Timer state
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_last;
  logic [PW-1:0] period_full;
  logic [4:0] tap;
  logic presc_wrap;
  logic overflow;
  logic counting;

  // Bus decode
  logic setup_cyc;
  logic wr_cyc;
  logic rd_cyc;
  logic sel_ok;
  logic [`WDT_ADDR_W-1:0] addr;
  logic hit_clksel;
  logic hit_mode;
  logic hit_status;
  logic hit_irqctl;
  logic [31:0] rd_word;

  // Write strobes
  logic clksel_wr;
  logic run_wr;
  logic loop_set;
  logic act_set;
  logic irqctl_wr;
  logic flag_set;
  logic flag_clr;

  // Mode and event terms
  wdt_pkg::wd_mode_t mode;
  logic irq_level;
  logic nmi_event;
  logic reset_event;
  logic pending_nmi;

  // Address decode
  assign addr = paddr[`WDT_ADDR_W-1:0];
  assign hit_clksel = (addr == `WDT_OFF_CLKSEL);
  assign hit_mode = (addr == `WDT_OFF_MODE);
  assign hit_status = (addr == `WDT_OFF_STATUS);
  assign hit_irqctl = (addr == `WDT_OFF_IRQCTL);
  assign sel_ok = hit_clksel || hit_mode || hit_status || hit_irqctl;
  assign setup_cyc = psel && !penable;
  assign wr_cyc = psel && penable && pwrite && pready;
  assign rd_cyc = setup_cyc && !pwrite;

  // Write strobes; zeros written to the mode bits are ignored
  assign clksel_wr = wr_cyc && hit_clksel;
  assign run_wr = wr_cyc && hit_mode && pwdata[`WDT_BIT_RUN];
  assign loop_set = wr_cyc && hit_mode && pwdata[`WDT_BIT_LOOP];
  assign act_set = wr_cyc && hit_mode && pwdata[`WDT_BIT_ACTION];
  assign irqctl_wr = wr_cyc && hit_irqctl;

  // Mode from the two mode bits
  always_comb
  begin
    unique case ({loop_detect_select_q, overflow_action_select_q})
      2'b00: mode = wdt_pkg::MODE_STOP;
      2'b01: mode = wdt_pkg::MODE_INTERVAL;
      2'b10: mode = wdt_pkg::MODE_WD_NMI;
      2'b11: mode = wdt_pkg::MODE_WD_RESET;
    endcase
  end

  // Prescaler tap for the selected period; prohibited codes fall back to 2^11
  always_comb
  begin
    unique case (wd_clock_select_register_q)
      `WDT_SEL_P13: tap = `WDT_TAP_P13;
      `WDT_SEL_P15: tap = `WDT_TAP_P15;
      `WDT_SEL_P17: tap = `WDT_TAP_P17;
      default: tap = `WDT_TAP_P11;
    endcase
  end

  // Last count value of the selected period
  assign period_full = {{(PW-1){1'b0}}, 1'b1} << tap;
  assign cnt_last = CNT_W'(period_full >> PRESC_W) - {{(CNT_W-1){1'b0}}, 1'b1};

  // Counting: halt keeps running, stop freezes; restart clears only the count
  assign presc_wrap = (presc_q == {PRESC_W{1'b1}});
  assign counting = run_q && (mode != wdt_pkg::MODE_STOP) && !cpu_stop;
  assign overflow = counting && presc_wrap && (cnt_q == cnt_last);
  assign presc_d = cpu_stop ? presc_q : presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};

  // Count register next value
  always_comb
  begin
    cnt_d = cnt_q;
    if (run_wr)
      cnt_d = {CNT_W{1'b0}};
    else if (overflow)
      cnt_d = {CNT_W{1'b0}};
    else if (counting && presc_wrap)
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Interval flag terms; hardware set wins over software clear
  assign flag_set = overflow && (mode == wdt_pkg::MODE_INTERVAL);
  assign flag_clr = irqctl_wr && !pwdata[`WDT_BIT_FLAG];

  // Event terms
  assign irq_level = interval_irq_flag_q && !interval_irq_mask_q && (mode == wdt_pkg::MODE_INTERVAL);
  assign pending_nmi = loop_set && !loop_detect_select_q && interval_irq_flag_q;
  assign nmi_event = (overflow && (mode == wdt_pkg::MODE_WD_NMI)) ||
                     pending_nmi;
  assign reset_event = overflow && (mode == wdt_pkg::MODE_WD_RESET);

  // Read data multiplexer
  always_comb
  begin
    unique case (addr)
      `WDT_OFF_CLKSEL: rd_word = {29'h0, wd_clock_select_register_q};
      `WDT_OFF_MODE: rd_word = {24'h0, run_q, 2'b00, loop_detect_select_q, overflow_action_select_q, 3'b000};
      `WDT_OFF_STATUS: rd_word = {31'h0, interval_irq_flag_q};
      `WDT_OFF_IRQCTL: rd_word = {30'h0, interval_irq_mask_q, interval_irq_flag_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus ready: one access cycle after every setup
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= setup_cyc;
  end

  // Bus error on unmapped addresses
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup_cyc && !sel_ok;
  end

  // Read data, zero for writes and unmapped reads
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_cyc)
    begin
      prdata <= rd_cyc ? rd_word : 32'h0000_0000;
    end
  end

  // Clock select register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wd_clock_select_register_q <= 3'h0;
    end
    else if (clksel_wr)
    begin
      wd_clock_select_register_q <= pwdata[2:0];
    end
  end

  // Run bit: set only, cleared by reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      run_q <= 1'b0;
    end
    else if (run_wr)
    begin
      run_q <= 1'b1;
    end
  end

  // Loop select bit: set only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      loop_detect_select_q <= 1'b0;
    end
    else if (loop_set)
    begin
      loop_detect_select_q <= 1'b1;
    end
  end

  // Action select bit: set only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      overflow_action_select_q <= 1'b0;
    end
    else if (act_set)
    begin
      overflow_action_select_q <= 1'b1;
    end
  end

  // Prescaler, held while cpu_stop is high, never cleared by a restart
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      presc_q <= {PRESC_W{1'b0}};
    else
      presc_q <= presc_d;
  end

  // Period counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cnt_q <= {CNT_W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

  // Interval request flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      interval_irq_flag_q <= 1'b0;
    end
    else if (flag_set)
    begin
      interval_irq_flag_q <= 1'b1;
    end
    else if (flag_clr)
    begin
      interval_irq_flag_q <= 1'b0;
    end
  end

  // Interval mask, masked after reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      interval_irq_mask_q <= 1'b1;
    end
    else if (irqctl_wr)
    begin
      interval_irq_mask_q <= pwdata[`WDT_BIT_MASK];
    end
  end

  // Maskable interval request
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      interval_irq_request <= 1'b0;
    end
    else
    begin
      interval_irq_request <= irq_level;
    end
  end

  // Top priority marker follows the request
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      interval_irq_high_priority <= 1'b0;
    else
      interval_irq_high_priority <= irq_level;
  end

  // Non-maskable interrupt pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wd_nmi <= 1'b0;
    end
    else
    begin
      wd_nmi <= nmi_event;
    end
  end

  // Reset request pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wd_reset_req <= 1'b0;
    else
      wd_reset_req <= reset_event;
  end
endmodule : watchdog_interval_timer
`default_nettype wire
